// ==== bench/flash_protection_key_status_tb.sv ====
// Self-checking bench for the flash protection block.
// Assumes the non-volatile store survives the resets issued here.
`timescale 1ns/1ps
`define CHK(g, e, m) begin \
   checked++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("[FAIL] %0t %s", $time, m); \
   end \
end
module flash_protection_key_status_tb;
   import fpk_pkg::*;
   logic           clk_in;
   logic           sys_rst_in;
   fpk_reg_req_s   reg_req;
   fpk_flash_req_s flash_req;
   logic [31:0]    rdata;
   logic [31:0]    prot;
   logic           grant;
   logic           deny;
   logic           busy;
   logic [31:0]    q;
   logic [7:0]     st;
   logic           b;
   int             failures = 0;
   int             checked = 0;
   fpk_flash_protect #(.OP_CYCLES(4)) dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_in(reg_req),
      .flash_in(flash_req), .rdata_out(rdata), .flash_grant_out(grant),
      .flash_deny_out(deny), .busy_out(busy), .active_prot_out(prot));
   fpk_host_model u_host (.clk_in(clk_in), .rdata_in(rdata),
                          .reg_out(reg_req));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // ==================================================================
   // Shared steps
   task automatic give_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic do_reset();
      @(negedge clk_in);
      sys_rst_in = 1'b1;
      repeat (5) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask
   task automatic access(input logic w, input fpk_path_e p,
                         input logic [15:0] a, input logic g);
      @(negedge clk_in);
      flash_req = '{valid: 1'b1, write: w, path: p, addr: a};
      @(negedge clk_in);
      flash_req = '{valid: 1'b0, write: ~w, path: p, addr: ~a};
      `CHK(grant, g, "grant mismatch")
      `CHK(deny, !g, "deny mismatch")
   endtask
   task automatic set_volatile(input logic [31:0] v);
      u_host.wr(FPK_ADDR_VOLAT, v);
      repeat (3) @(negedge clk_in);
   endtask
   // ==================================================================
   // Scenarios
   task automatic t_regs();
      u_host.rd(FPK_ADDR_STATUS, q);
      `CHK(q, {24'h0, FPK_STATUS_RST}, "status reset value")
      u_host.wr(FPK_ADDR_STATUS, 32'h000000ff);
      u_host.rd(FPK_ADDR_STATUS, q);
      `CHK(q, {24'h0, FPK_STATUS_RST}, "status written")
      `CHK(prot, FPK_PROT_ERASED, "protection after reset")
      u_host.rd(FPK_ADDR_VOLAT, q);
      `CHK(q, 32'hffffffff, "volatile reset value")
      u_host.wr(FPK_ADDR_MODE, 32'h00000048);
      u_host.rd(FPK_ADDR_MODE, q);
      `CHK(q, 32'h00000048, "mode readback")
      u_host.wr(FPK_ADDR_COMMAND, {24'h0, FPK_CMD_MASS_ERASE});
      `CHK(busy, 1'b0, "busy before run")
      u_host.wr(FPK_ADDR_COMMAND, {24'h0, FPK_CMD_SAVE_PROT});
      `CHK(busy, 1'b1, "busy not raised")
      repeat (2) @(negedge clk_in);
      `CHK(busy, 1'b1, "busy ended early")
      @(negedge clk_in);
      `CHK(busy, 1'b0, "busy held too long")
      u_host.rd(FPK_ADDR_COMMAND, q);
      `CHK(q, {24'h0, FPK_CMD_MASS_ERASE}, "busy command taken")
      u_host.rd(FPK_ADDR_STATUS, q);
      `CHK(q[7:0], FPK_STATUS_RST | 8'h09, "erase flags")
      u_host.rd(32'hfffff814, q);
      `CHK(q, 32'h00000000, "unmapped read")
      $display("test regs done");
   endtask
   task automatic t_volatile();
      set_volatile(32'hfffffffd);
      `CHK(prot, 32'hfffffffd, "volatile not applied")
      for (int i = 0; i < 3; i++) begin
         access(1'b1, fpk_path_e'(i), 16'h0800, 1'b0);
         access(1'b1, fpk_path_e'(i), 16'h0fff, 1'b0);
         access(1'b1, fpk_path_e'(i), 16'h07ff, 1'b1);
         access(1'b1, fpk_path_e'(i), 16'h1000, 1'b1);
      end
      access(1'b0, FPK_PATH_DEBUG, 16'h0800, 1'b1);
      set_volatile(32'h7fffffff);
      access(1'b0, FPK_PATH_DEBUG, 16'h0000, 1'b0);
      access(1'b0, FPK_PATH_SERIAL, 16'hf7fe, 1'b1);
      access(1'b1, FPK_PATH_CODE, 16'h0800, 1'b1);
      set_volatile(32'hfffffffd);
      do_reset();
      `CHK(prot, FPK_PROT_ERASED, "volatile survived reset")
      $display("test volatile done");
   endtask
   task automatic t_save();
      u_host.key_save(32'hfffffffb, 8'h48, 32'h12345678, st, b);
      `CHK(st[3:0], 4'b1001, "save pass with flag")
      `CHK(b, 1'b1, "busy never seen")
      u_host.rd(FPK_ADDR_STATUS, q);
      `CHK(q[3:0], 4'b0000, "flags not cleared by read")
      `CHK(prot, FPK_PROT_ERASED, "save acted before reset")
      do_reset();
      `CHK(prot, 32'hfffffffb, "saved word not loaded")
      access(1'b1, FPK_PATH_SERIAL, 16'h1000, 1'b0);
      u_host.key_save(32'hfffffffe, 8'h40, 32'h11112222, st, b);
      `CHK(st[3:0], 4'b0010, "wrong key not failed")
      u_host.rd(FPK_ADDR_STATUS, q);
      `CHK(q[1], 1'b0, "fail flag not cleared")
      u_host.key_save(32'hfffffffe, 8'h60, 32'h12345678, st, b);
      `CHK(st[3:0], 4'b0010, "bit 5 not refused")
      do_reset();
      `CHK(prot, 32'hfffffffb, "wrong key changed word")
      u_host.key_save(32'hfffffffe, 8'h40, 32'h12345678, st, b);
      `CHK(st[3:0], 4'b0001, "same key refused")
      do_reset();
      `CHK(prot, 32'hfffffffe, "new word not loaded")
      $display("test save done");
   endtask
   task automatic t_lock();
      u_host.erase(st, b);
      `CHK(st[3:0], 4'b1001, "erase failed")
      do_reset();
      `CHK(prot, FPK_PROT_ERASED, "erase kept protection")
      u_host.key_save(32'h7fffffff, 8'h40, FPK_KEY_LOCK, st, b);
      `CHK(st[3:0], 4'b0001, "lock key save failed")
      do_reset();
      `CHK(prot, 32'h7fffffff, "lock word not loaded")
      access(1'b0, FPK_PATH_DEBUG, 16'h0400, 1'b0);
      u_host.key_save(32'hffffffff, 8'h40, FPK_KEY_LOCK, st, b);
      `CHK(st[3:0], 4'b0010, "locked part accepted key")
      do_reset();
      `CHK(prot, 32'h7fffffff, "locked word changed")
      u_host.erase(st, b);
      do_reset();
      `CHK(prot, FPK_PROT_ERASED, "erase did not unlock")
      $display("test lock done");
   endtask
   initial begin
      sys_rst_in = 1'b1;
      flash_req = '0;
      do_reset();
      t_regs();
      t_volatile();
      t_save();
      t_lock();
      give_verdict();
   end
   initial begin
      #1000000;
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule

// ==== bench/fpk_flash_protect_props.sv ====
// Checker for the flash protection block, watching its ports only.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module fpk_flash_protect_props
   import fpk_pkg::*;
#(
   parameter int OP_CYCLES = FPK_OP_CYCLES
) (
   input wire logic                    clk_in,
   input wire logic                    sys_rst_in,
   input wire fpk_pkg::fpk_reg_req_s   reg_in,
   input wire fpk_pkg::fpk_flash_req_s flash_in,
   input wire logic [31:0]             rdata_out,
   input wire logic                    flash_grant_out,
   input wire logic                    flash_deny_out,
   input wire logic                    busy_out,
   input wire logic [31:0]             active_prot_out
);
   localparam int BUSY_MAX = OP_CYCLES + 8;
   logic [4:0] grp;
   logic       is_wr;
   logic       is_rd;
   assign grp   = flash_in.addr[15:11];
   assign is_wr = flash_in.valid && flash_in.write && grp != 5'h1f;
   assign is_rd = flash_in.valid && !flash_in.write;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // ==================================================================
   // Flash screen
   property p_one_answer;
      flash_in.valid |=> flash_grant_out ^ flash_deny_out;
   endproperty
   a_one_answer: assert property (p_one_answer)
      else $error("flash access without a single answer");
   property p_quiet;
      !flash_in.valid |=> !flash_grant_out && !flash_deny_out;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("flash answer without a request");
   property p_wr_guard;
      is_wr && !active_prot_out[grp] |=> flash_deny_out;
   endproperty
   a_wr_guard: assert property (p_wr_guard)
      else $error("write to protected group not denied");
   property p_wr_free;
      is_wr && active_prot_out[grp] |=> flash_grant_out;
   endproperty
   a_wr_free: assert property (p_wr_free)
      else $error("write to free group not granted");
   property p_dbg_read;
      is_rd && flash_in.path == FPK_PATH_DEBUG
         && !active_prot_out[FPK_READ_PROT] |=> flash_deny_out;
   endproperty
   a_dbg_read: assert property (p_dbg_read)
      else $error("debug read of protected flash not denied");
   property p_other_read;
      is_rd && flash_in.path != FPK_PATH_DEBUG |=> flash_grant_out;
   endproperty
   a_other_read: assert property (p_other_read)
      else $error("non-debug read denied");
   // ==================================================================
   // Registers and status
   property p_rdata_idle;
      !reg_in.rd |=> rdata_out == 32'h00000000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data without a read");
   property p_persist_lag;
      reg_in.wr && reg_in.addr == FPK_ADDR_PERSIST
         |=> $stable(active_prot_out) [*4];
   endproperty
   a_persist_lag: assert property (p_persist_lag)
      else $error("persistent write acted at once");
   property p_busy_end;
      busy_out |-> ##[1:BUSY_MAX] !busy_out;
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("busy outlasted the operation");
   property p_reset_prot;
      $fell(sys_rst_in) |-> active_prot_out == FPK_PROT_ERASED;
   endproperty
   a_reset_prot: assert property (p_reset_prot)
      else $error("protection word not free right after reset");
   c_deny: cover property (flash_in.valid ##1 flash_deny_out);
   c_busy: cover property ($rose(busy_out));
   c_dbg:  cover property (is_rd && !active_prot_out[FPK_READ_PROT]);
endmodule

bind fpk_flash_protect fpk_flash_protect_props #(
   .OP_CYCLES(OP_CYCLES)
) u_props (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_in(reg_in),
   .flash_in(flash_in), .rdata_out(rdata_out),
   .flash_grant_out(flash_grant_out), .flash_deny_out(flash_deny_out),
   .busy_out(busy_out), .active_prot_out(active_prot_out)
);

// ==== bench/fpk_host_model.sv ====
// Software or programmer side: register cycles and key sequences.
// Assumes strobes are taken on the rising edge after they are raised.
`timescale 1ns/1ps
module fpk_host_model
   import fpk_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic [31:0]       rdata_in,
   output fpk_pkg::fpk_reg_req_s  reg_out
);
   initial reg_out = '0;
   // Released lines show the inverse so stale values never match
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge clk_in);
      reg_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_in);
      reg_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      @(negedge clk_in);
      reg_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(negedge clk_in);
      q = rdata_in;
      reg_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hffffffff};
   endtask
   // poll status until the command settles
   task automatic poll(output logic [7:0] st, output logic seen);
      logic [31:0] q;
      seen = 1'b0;
      repeat (2) @(negedge clk_in);
      for (int i = 0; i < 40; i++) begin
         rd(FPK_ADDR_STATUS, q);
         seen = seen | q[FPK_ST_BUSY];
         if (!q[FPK_ST_BUSY] && (q[FPK_ST_PASS] || q[FPK_ST_FAIL]))
            break;
      end
      st = q[7:0];
   endtask
   task automatic key_save(input logic [31:0] prot, input logic [7:0] mode,
                           input logic [31:0] key, output logic [7:0] st,
                           output logic seen);
      wr(FPK_ADDR_PERSIST, prot);
      wr(FPK_ADDR_MODE, {24'h0, mode});
      wr(FPK_ADDR_ADDRESS, {16'h0, key[31:16]});
      wr(FPK_ADDR_DATA, {16'h0, key[15:0]});
      wr(FPK_ADDR_COMMAND, {24'h0, FPK_CMD_SAVE_PROT});
      poll(st, seen);
   endtask
   task automatic erase(output logic [7:0] st, output logic seen);
      wr(FPK_ADDR_MODE, 32'h00000008);
      wr(FPK_ADDR_COMMAND, {24'h0, FPK_CMD_MASS_ERASE});
      poll(st, seen);
   endtask
endmodule

// ==== hw/fpk_access_guard.sv ====
// Screens flash array accesses against the active protection word.
// Assumes one access request per cycle, addresses in bytes.
`timescale 1ns/1ps
module fpk_access_guard #(
   parameter int GROUP_BYTES = 2048
) (
   input  wire logic                    clk_in,
   input  wire logic                    sys_rst_in,
   input  wire fpk_pkg::fpk_flash_req_s req_in,
   input  wire logic [31:0]             active_prot_in,
   output logic                         grant_out,
   output logic                         deny_out
);
   import fpk_pkg::*;

   localparam int SHIFT = $clog2(GROUP_BYTES);

   if (GROUP_BYTES != 2048) begin : g_bad_group
      $error("group size must be 2 kB");
   end

   logic [4:0] group;
   logic       blocked;
   logic       group_prot;

   always_comb begin
      group = 5'(req_in.addr >> SHIFT);
      // Cleared bit means protected, as erased flash reads all ones
      group_prot = (group < 5'd31) ? !active_prot_in[group] : 1'b0;
      blocked = 1'b0;
      if (req_in.write && group_prot)
         blocked = 1'b1;
      if (!req_in.write && req_in.path == FPK_PATH_DEBUG &&
          !active_prot_in[FPK_READ_PROT])
         blocked = 1'b1;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         grant_out <= 1'b0;
         deny_out  <= 1'b0;
      end else begin
         grant_out <= req_in.valid && !blocked;
         deny_out  <= req_in.valid && blocked;
      end
   end
endmodule

// ==== hw/fpk_flash_protect.sv ====
// Flash protection, key and status control.
// Assumes registers are shared by code, serial and debug paths.
// Contract
// - Protection bit 31 active blocks debug-port reads of user flash.
// - Each other bit guards a four-page 2 kB group against writes.
// - Write guard applies to every access path alike.
// - Volatile protection acts when written and is lost at reset.
// - Persistent value acts only after save command and a reset.
// - Saved key must be supplied again to change persistent protection.
// - Mass erase restores erased key and is the only unlock.
// - Lock key value refuses every later key entry.
// - Status bit 3 on completion with interrupt enable; read clears.
// - Status bit 2 follows busy state.
// - Status bit 1 on failure; read clears.
// - Status bit 0 on success; read clears.
// - Status register read-only at fixed address, reset 0x20.
// - Eight shared memory-mapped control registers; sign register is not implemented and its address reads zero.
`timescale 1ns/1ps
module fpk_flash_protect #(
   parameter int OP_CYCLES = fpk_pkg::FPK_OP_CYCLES
) (
   input  wire logic                    clk_in,
   input  wire logic                    sys_rst_in,
   input  wire fpk_pkg::fpk_reg_req_s   reg_in,
   input  wire fpk_pkg::fpk_flash_req_s flash_in,
   output logic [31:0]                  rdata_out,
   output logic                         flash_grant_out,
   output logic                         flash_deny_out,
   output logic                         busy_out,
   output logic [31:0]                  active_prot_out
);
   import fpk_pkg::*;

   // Run counter is 16 bits wide
   if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : g_bad_cycles
      $error("OP_CYCLES out of range");
   end

   typedef enum logic [1:0] {FPK_IDLE, FPK_RUN, FPK_DONE} fpk_state_e;

   fpk_state_e  state;
   logic [15:0] op_count;
   logic [7:0]  status;
   logic [7:0]  mode;
   logic [7:0]  command;
   logic [15:0] data_word;
   logic [15:0] addr_word;
   logic [31:0] persist_shadow;
   logic [31:0] volatile_prot;
   logic [31:0] applied_prot;
   logic [31:0] active_prot;
   fpk_nv_s     nv = '{prot: FPK_PROT_ERASED, key: FPK_KEY_ERASED};
   logic        op_ok;
   logic [7:0]  op_cmd;
   logic        boot_load;

   logic wr_mode;
   logic wr_cmd;
   logic wr_data;
   logic wr_addr;
   logic wr_persist;
   logic wr_volat;
   logic rd_status;
   logic key_match;
   logic key_locked;
   logic op_finish;

   // ==================================================================
   // Address decode
   // seven shared registers; sign address not decoded
   always_comb begin
      wr_mode    = 1'b0;
      wr_cmd     = 1'b0;
      wr_data    = 1'b0;
      wr_addr    = 1'b0;
      wr_persist = 1'b0;
      wr_volat   = 1'b0;
      // Full byte addresses match; no aliasing
      // Status is read-only: a write to it matches no branch
      if (reg_in.addr == FPK_ADDR_MODE)
         wr_mode = reg_in.wr;
      else if (reg_in.addr == FPK_ADDR_COMMAND)
         wr_cmd = reg_in.wr;
      else if (reg_in.addr == FPK_ADDR_DATA)
         wr_data = reg_in.wr;
      else if (reg_in.addr == FPK_ADDR_ADDRESS)
         wr_addr = reg_in.wr;
      else if (reg_in.addr == FPK_ADDR_PERSIST)
         wr_persist = reg_in.wr;
      else if (reg_in.addr == FPK_ADDR_VOLAT)
         wr_volat = reg_in.wr;
      rd_status = reg_in.rd && (reg_in.addr == FPK_ADDR_STATUS);
   end

   // ==================================================================
   // Key checks
   always_comb begin
      // supplied key must match
      // Erased key means nothing saved yet, so any key is taken
      key_match  = ({addr_word, data_word} == nv.key) ||
                   (nv.key == FPK_KEY_ERASED);
      key_locked = (nv.key == FPK_KEY_LOCK);
      op_finish  = (state == FPK_RUN) && (op_count == 16'h0001);
   end

   // ==================================================================
   // Plain writable registers
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode           <= FPK_MODE_RST;
         data_word      <= 16'h0000;
         addr_word      <= 16'h0000;
         persist_shadow <= FPK_PROT_ERASED;
      end else begin
         if (wr_mode)
            mode <= reg_in.wdata[7:0];
         if (wr_data)
            data_word <= reg_in.wdata[15:0];
         if (wr_addr)
            addr_word <= reg_in.wdata[15:0];
         if (wr_persist)
            persist_shadow <= reg_in.wdata;
      end
   end

   // volatile acts at once, set to all ones on reset
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         volatile_prot <= FPK_PROT_ERASED;
      else if (wr_volat)
         volatile_prot <= reg_in.wdata;
   end

   // ==================================================================
   // Command sequencer
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state    <= FPK_IDLE;
         op_count <= 16'h0000;
         op_cmd   <= 8'h00;
         op_ok    <= 1'b0;
      end else begin
         case (state)
            FPK_IDLE: begin
               if (wr_cmd) begin
                  op_cmd   <= reg_in.wdata[7:0];
                  op_count <= 16'(OP_CYCLES);
                  state    <= FPK_RUN;
                  if (reg_in.wdata[7:0] == FPK_CMD_SAVE_PROT)
                     op_ok <= mode[FPK_MODE_KEY_EN] &&
                              !mode[FPK_MODE_KEY_B5] &&
                              key_match && !key_locked;
                  else
                     op_ok <= (reg_in.wdata[7:0] == FPK_CMD_MASS_ERASE);
               end
            end
            FPK_RUN: begin
               op_count <= op_count - 16'h0001;
               if (op_finish)
                  state <= FPK_DONE;
            end
            FPK_DONE: begin
               state <= FPK_IDLE;
            end
            default: begin
               state <= FPK_IDLE;
            end
         endcase
      end
   end

   // Last accepted command for read-back; writes while not idle drop
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         command <= 8'h00;
      else if (wr_cmd && state == FPK_IDLE)
         command <= reg_in.wdata[7:0];
   end

   // ==================================================================
   // Non-volatile store model
   // Contents kept across the block reset; a mass erase blanks it, and so does power-up,
   // through the initial value given where the store is declared
   always_ff @(posedge clk_in) begin
      if (op_finish && op_ok) begin
         if (op_cmd == FPK_CMD_SAVE_PROT) begin
            nv.prot <= persist_shadow;
            nv.key  <= {addr_word, data_word};
         end else if (op_cmd == FPK_CMD_MASS_ERASE) begin
            nv.prot <= FPK_PROT_ERASED;
            nv.key  <= FPK_KEY_ERASED;
         end
      end
   end

   // load saved value after reset release
   // saved value applies only here
   // Store read one cycle after release, off the reset path
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         boot_load    <= 1'b1;
         applied_prot <= FPK_PROT_ERASED;
      end else if (boot_load) begin
         boot_load    <= 1'b0;
         applied_prot <= nv.prot;
      end
   end

   // Cleared bit in either source protects
   always_comb begin
      active_prot = applied_prot & volatile_prot;
   end

   // ==================================================================
   // Status: hardware set wins over read clear
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status <= FPK_STATUS_RST;
      end else begin
         // Read clear first, so a same-cycle set below wins
         if (rd_status)
            status[FPK_ST_IRQ:FPK_ST_PASS] <= 4'h0;
         // busy follows controller
         // Raised on the accepted command edge so a poll never misses it
         status[FPK_ST_BUSY] <= (state == FPK_RUN) ||
                                (wr_cmd && state == FPK_IDLE);
         if (op_finish) begin
            if (op_ok)
               status[FPK_ST_PASS] <= 1'b1;
            else
               status[FPK_ST_FAIL] <= 1'b1;
            if (mode[FPK_MODE_IRQ_EN])
               status[FPK_ST_IRQ] <= 1'b1;
         end
      end
   end

   // ==================================================================
   // Status outputs
   // Registered copies; they trail the internal state by one cycle
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         busy_out        <= 1'b0;
         active_prot_out <= FPK_PROT_ERASED;
      end else begin
         busy_out        <= (state == FPK_RUN);
         active_prot_out <= active_prot;
      end
   end

   // ==================================================================
   // Read data
   // status read-only at fixed address
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_out <= FPK_ZERO32;
      end else begin
         // Unmapped and sign reads return zero
         rdata_out <= FPK_ZERO32;
         if (reg_in.rd) begin
            if (reg_in.addr == FPK_ADDR_STATUS)
               rdata_out <= {24'h000000, status};
            else if (reg_in.addr == FPK_ADDR_MODE)
               rdata_out <= {24'h000000, mode};
            else if (reg_in.addr == FPK_ADDR_COMMAND)
               rdata_out <= {24'h000000, command};
            else if (reg_in.addr == FPK_ADDR_DATA)
               rdata_out <= {16'h0000, data_word};
            else if (reg_in.addr == FPK_ADDR_ADDRESS)
               rdata_out <= {16'h0000, addr_word};
            else if (reg_in.addr == FPK_ADDR_PERSIST)
               rdata_out <= persist_shadow;
            else if (reg_in.addr == FPK_ADDR_VOLAT)
               rdata_out <= volatile_prot;
         end
      end
   end

   fpk_access_guard #(
      .GROUP_BYTES (2048)
   ) u_guard (
      .clk_in         (clk_in),
      .sys_rst_in     (sys_rst_in),
      .req_in         (flash_in),
      .active_prot_in (active_prot),
      .grant_out      (flash_grant_out),
      .deny_out       (flash_deny_out)
   );
endmodule

// ==== hw/fpk_pkg.sv ====
// Package for the flash protection, key and status block.
// Assumes a 32-bit memory-mapped register port driven by the core or
// the download/debug paths, all synchronous to clk_in.
package fpk_pkg;

   // ==================================================================
   // Register map (byte addresses, eight control registers)
   localparam logic [31:0] FPK_ADDR_STATUS  = 32'hfffff800;
   localparam logic [31:0] FPK_ADDR_MODE    = 32'hfffff804;
   localparam logic [31:0] FPK_ADDR_COMMAND = 32'hfffff808;
   localparam logic [31:0] FPK_ADDR_DATA    = 32'hfffff80c;
   localparam logic [31:0] FPK_ADDR_ADDRESS = 32'hfffff810;
   localparam logic [31:0] FPK_ADDR_SIGN    = 32'hfffff818;
   localparam logic [31:0] FPK_ADDR_PERSIST = 32'hfffff81c;
   localparam logic [31:0] FPK_ADDR_VOLAT   = 32'hfffff820;

   // ==================================================================
   // Fields and reset values
   localparam logic [7:0]  FPK_STATUS_RST   = 8'h20;
   localparam int          FPK_ST_PASS      = 0;
   localparam int          FPK_ST_FAIL      = 1;
   localparam int          FPK_ST_BUSY      = 2;
   localparam int          FPK_ST_IRQ       = 3;
   localparam int          FPK_MODE_IRQ_EN  = 3;
   localparam int          FPK_MODE_KEY_EN  = 6;
   localparam int          FPK_MODE_KEY_B5  = 5;
   localparam int          FPK_READ_PROT    = 31;
   localparam logic [7:0]  FPK_MODE_RST     = 8'h00;
   localparam logic [31:0] FPK_KEY_ERASED   = 32'hffffffff;
   localparam logic [31:0] FPK_KEY_LOCK     = 32'hdeaddead;
   localparam logic [31:0] FPK_PROT_ERASED  = 32'hffffffff;
   localparam logic [31:0] FPK_ZERO32       = 32'h00000000;

   // ==================================================================
   // Commands and timing
   localparam logic [7:0]  FPK_CMD_SAVE_PROT  = 8'h0c;
   localparam logic [7:0]  FPK_CMD_MASS_ERASE = 8'h06;
   localparam int          FPK_CLK_MHZ        = 40;
   localparam int          FPK_OP_TIME_US     = 20;
   localparam int          FPK_OP_CYCLES      = FPK_OP_TIME_US * FPK_CLK_MHZ;

   typedef enum logic [1:0] {
      FPK_PATH_CODE,
      FPK_PATH_SERIAL,
      FPK_PATH_DEBUG
   } fpk_path_e;

   // Register access bundle
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } fpk_reg_req_s;

   // Flash array access to be screened
   typedef struct packed {
      logic        valid;
      logic        write;
      fpk_path_e   path;
      logic [15:0] addr;
   } fpk_flash_req_s;

   // Non-volatile store image
   typedef struct packed {
      logic [31:0] prot;
      logic [31:0] key;
   } fpk_nv_s;

endpackage
